// [smdc_peer.sv]
// Serial line partner: 8N1 sender and receiver
`timescale 1ns/1ps
module smdc_peer (
	input wire logic i_clk,
	input wire logic [15:0] i_div,
	input wire logic i_line,
	output logic o_line
);
	logic [7:0] q[$];
	logic [7:0] b;
	initial o_line = 1'b1;
	task automatic send(input logic [7:0] d);
		@(posedge i_clk);
		o_line <= 1'b0;
		repeat (i_div) @(posedge i_clk);
		for (int k = 0; k < 8; k++) begin
			o_line <= d[k];
			repeat (i_div) @(posedge i_clk);
		end
		o_line <= 1'b1;
		repeat (i_div) @(posedge i_clk);
	endtask
	always begin
		@(negedge i_line);
		repeat (i_div / 2) @(posedge i_clk);
		for (int k = 0; k < 8; k++) begin
			repeat (i_div) @(posedge i_clk);
			b[k] = i_line;
		end
		repeat (i_div) @(posedge i_clk);
		if (i_line === 1'b1) q.push_back(b);
	end
endmodule

// [smdc_pkg.sv]
// Package of constants for the serial multidrop front end
package smdc_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int BAUD_38400 = 38400;
	localparam logic [15:0] DIV_4800 = 16'(CLK_HZ / BAUD_4800);
	localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / BAUD_9600);
	localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / BAUD_19200);
	localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / BAUD_38400);
	localparam int DATA_BITS = 8;
	localparam int STOP_BITS = 1;
	localparam logic [1:0] BAUD_SEL_4800 = 2'h0;
	localparam logic [1:0] BAUD_SEL_9600 = 2'h1;
	localparam logic [1:0] BAUD_SEL_19200 = 2'h2;
	localparam logic [1:0] BAUD_SEL_38400 = 2'h3;
	localparam logic [3:0] ADDR_BAUD = 4'h0;
	localparam logic [3:0] ADDR_MODE = 4'h1;
	localparam logic [3:0] ADDR_NAME = 4'h2;
	localparam logic [3:0] ADDR_CMD = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_TXD = 4'h5;
	localparam logic [3:0] ADDR_RXD = 4'h6;
	localparam int MODE_HUB_BIT = 0;
	localparam int MODE_ADDR_BIT = 1;
	localparam int CMD_SAVE_BIT = 0;
	localparam logic [1:0] BAUD_RST = BAUD_SEL_19200;
	localparam logic [7:0] NAME_DEFAULT = 8'h21;
	localparam logic [7:0] CHAR_A = 8'h41;
	localparam logic [7:0] CHAR_UP_Z = 8'h5a;
	localparam logic [7:0] CHAR_LO_A = 8'h61;
	localparam logic [7:0] CHAR_LO_Z = 8'h7a;
	localparam logic [7:0] CHAR_0 = 8'h30;
	localparam logic [7:0] CHAR_9 = 8'h39;
	localparam logic [7:0] CHAR_LF = 8'h0a;
	localparam logic [7:0] CHAR_CR = 8'h0d;
endpackage

// [smdc_props.sv]
// Property checker for the serial multidrop front end
`timescale 1ns/1ps
module smdc_props (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_hub_role_switch,
	input wire logic i_addressed_mode_switch,
	input wire logic [3:0] i_addr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_rs232_tx,
	input wire logic o_rs485_tx,
	input wire logic o_rs485_oe,
	input wire logic o_nv_we,
	input wire logic o_hub_active,
	input wire logic o_addressed_active
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_go485;
		$fell(o_rs485_tx);
	endsequence
	sequence s_low485;
		(!o_rs485_tx) [*8];
	endsequence
	sequence s_go232;
		$fell(o_rs232_tx);
	endsequence
	sequence s_low232;
		(!o_rs232_tx) [*8];
	endsequence
	chk_oe_on_start: assert property (s_go485 |-> o_rs485_oe) else $error("rs485 sends undriven");
	chk_start485_len: assert property (s_go485 |-> s_low485) else $error("rs485 start short");
	chk_start232_len: assert property (s_go232 |-> s_low232) else $error("rs232 start short");
	chk_idle_line: assert property (!o_rs485_oe |-> o_rs485_tx) else $error("rs485 not idle");
	chk_hub_switch: assert property (i_hub_role_switch |-> ##[1:4] o_hub_active) else $error("hub off");
	chk_addr_switch: assert property (i_addressed_mode_switch |-> ##[1:4] o_addressed_active)
		else $error("addressed off");
	chk_save_pulse: assert property (o_nv_we |=> !o_nv_we) else $error("save pulse long");
	chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("rdata not zero");
	chk_unmapped_rd: assert property (i_rd && i_addr > 4'h6 |=> o_rdata == 8'h00) else $error("unmapped read");
endmodule
bind smdc_top smdc_props smdc_props_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
	.i_hub_role_switch(i_hub_role_switch), .i_addressed_mode_switch(i_addressed_mode_switch),
	.i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rs232_tx(o_rs232_tx), .o_rs485_tx(o_rs485_tx),
	.o_rs485_oe(o_rs485_oe), .o_nv_we(o_nv_we), .o_hub_active(o_hub_active), .o_addressed_active(o_addressed_active));

// [smdc_top.sv]
// Serial multidrop front end: two channels, hub relay, node naming
// Summary of operation
// - Both channels share one selectable rate: 4800, 9600, 19200 or 38400.
// - Rate after reset is 19200 until software changes it.
// - Characters are eight data bits, one stop bit, no parity.
// - Factory default: addressed switch off and addressed flag zero.
// - Unaddressed talk only when both addressed switch and flag are inactive.
// - Hub role when switch two is on or the hub flag is one.
// - Hub relays each host RS-232 character onto RS-485 unless the RS-485 sender is still busy.
// - Hub relays RS-485 replies back to the host over RS-232.
// - Addressed mode when switch three is on or addressed flag is one.
// - Address switches are binary, top switch MSB; 1..7 give names A..G.
// - A name command sets the node name to a single character.
// - Without an assigned name the node answers to exclamation mark.
// - Accepted software names are ASCII letters of either case or digits.
// - Save writes the software-assigned node name and the addressed flag to non-volatile storage.
// - A saved addressed flag keeps addressed mode with the switch off.
`timescale 1ns/1ps
module smdc_top (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_hub_role_switch,
	input wire logic i_addressed_mode_switch,
	input wire logic [2:0] i_node_address_switches,
	input wire logic [7:0] i_nv_name,
	input wire logic i_nv_addr_flag,
	input wire logic i_nv_valid,
	input wire logic i_rs232_rx,
	input wire logic i_rs485_rx,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_rs232_tx,
	output logic o_rs485_tx,
	output logic o_rs485_oe,
	output logic o_nv_we,
	output logic [7:0] o_nv_name,
	output logic o_nv_addr_flag,
	output logic o_hub_active,
	output logic o_addressed_active
);
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	logic [1:0] baud_q;
	logic hub_flag_q, addr_flag_q;
	logic [7:0] name_q;
	logic nv_loaded_q;
	logic [7:0] txd_q;
	logic tx_req_q;
	logic [7:0] rxd_q;
	logic rx_new_q;
	logic name_rej_q;
	logic msg_sel_q, msg_start_q;

	// Divider selection
	wire [15:0] div = (baud_q == smdc_pkg::BAUD_SEL_4800) ? smdc_pkg::DIV_4800 :
		(baud_q == smdc_pkg::BAUD_SEL_9600) ? smdc_pkg::DIV_9600 :
		(baud_q == smdc_pkg::BAUD_SEL_19200) ? smdc_pkg::DIV_19200 : smdc_pkg::DIV_38400;

	wire hub_on = i_hub_role_switch | hub_flag_q;
	wire addr_on = i_addressed_mode_switch | addr_flag_q;
	wire single_ok = ~i_addressed_mode_switch & ~addr_flag_q;

	// Effective node name
	wire [7:0] sw_name = smdc_pkg::CHAR_A + {5'h00, i_node_address_switches} - 8'h01;
	wire [7:0] node_name = (i_node_address_switches != 3'h0) ? sw_name : name_q;

	wire is_upper = (i_wdata >= smdc_pkg::CHAR_A) && (i_wdata <= smdc_pkg::CHAR_UP_Z);
	wire is_lower = (i_wdata >= smdc_pkg::CHAR_LO_A) && (i_wdata <= smdc_pkg::CHAR_LO_Z);
	wire is_digit = (i_wdata >= smdc_pkg::CHAR_0) && (i_wdata <= smdc_pkg::CHAR_9);
	wire name_ok = is_upper | is_lower | is_digit;

	wire wr_baud = i_wr && (i_addr == smdc_pkg::ADDR_BAUD);
	wire wr_mode = i_wr && (i_addr == smdc_pkg::ADDR_MODE);
	wire wr_name = i_wr && (i_addr == smdc_pkg::ADDR_NAME);
	wire wr_cmd = i_wr && (i_addr == smdc_pkg::ADDR_CMD);
	wire wr_txd = i_wr && (i_addr == smdc_pkg::ADDR_TXD);
	wire rd_rxd = i_rd && (i_addr == smdc_pkg::ADDR_RXD);

	// Serial engines
	logic r232_v, r485_v, t232_busy, t485_busy;
	logic [7:0] r232_d, r485_d;
	logic t232_go, t485_go;
	logic [7:0] t232_dat, t485_dat;
	logic t232_tx, t485_tx;

	smdc_uart_rx #(.DW(smdc_pkg::DATA_BITS)) u_rx232 (
		.i_clk(i_core_clk), .i_rst_n(rst_n_q), .i_div(div), .i_rx(i_rs232_rx),
		.o_valid(r232_v), .o_data(r232_d)
	);
	smdc_uart_rx #(.DW(smdc_pkg::DATA_BITS)) u_rx485 (
		.i_clk(i_core_clk), .i_rst_n(rst_n_q), .i_div(div), .i_rx(i_rs485_rx),
		.o_valid(r485_v), .o_data(r485_d)
	);
	smdc_uart_tx #(.DW(smdc_pkg::DATA_BITS)) u_tx232 (
		.i_clk(i_core_clk), .i_rst_n(rst_n_q), .i_div(div), .i_start(t232_go), .i_data(t232_dat),
		.o_busy(t232_busy), .o_tx(t232_tx)
	);
	smdc_uart_tx #(.DW(smdc_pkg::DATA_BITS)) u_tx485 (
		.i_clk(i_core_clk), .i_rst_n(rst_n_q), .i_div(div), .i_start(t485_go), .i_data(t485_dat),
		.o_busy(t485_busy), .o_tx(t485_tx)
	);

	// Hub relays; host channel for local traffic is RS-232 unless a non-hub node on RS-485
	wire host_rx_v = hub_on ? r232_v : r485_v;
	wire [7:0] host_rx_d = hub_on ? r232_d : r485_d;
	// Addressed filtering: leading character selects the message
	wire msg_first = host_rx_v && msg_start_q;
	wire sel_now = msg_first ? (host_rx_d == node_name) : msg_sel_q;
	wire accept = host_rx_v && (addr_on ? (sel_now && !msg_first) : single_ok);
	wire msg_end = host_rx_v && ((host_rx_d == smdc_pkg::CHAR_CR) || (host_rx_d == smdc_pkg::CHAR_LF));

	wire relay_232_485 = hub_on && r232_v && !t485_busy;
	wire relay_485_232 = hub_on && r485_v && !t232_busy;
	wire local_on_485 = !hub_on;
	wire local_go = tx_req_q && (local_on_485 ? !t485_busy : !t232_busy) && !(hub_on && r485_v);
	assign t485_go = relay_232_485 || (local_on_485 && local_go);
	assign t485_dat = relay_232_485 ? r232_d : txd_q;
	assign t232_go = relay_485_232 || (!local_on_485 && local_go && !relay_485_232);
	assign t232_dat = relay_485_232 ? r485_d : txd_q;

	wire [7:0] status = {1'b0, name_rej_q, single_ok, addr_on, hub_on, tx_req_q, rx_new_q, nv_loaded_q};
	wire [7:0] rd_mux = (i_addr == smdc_pkg::ADDR_BAUD) ? {6'h00, baud_q} :
		(i_addr == smdc_pkg::ADDR_MODE) ? {6'h00, addr_flag_q, hub_flag_q} :
		(i_addr == smdc_pkg::ADDR_NAME) ? node_name :
		(i_addr == smdc_pkg::ADDR_STATUS) ? status :
		(i_addr == smdc_pkg::ADDR_RXD) ? rxd_q : 8'h00;

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			baud_q <= smdc_pkg::BAUD_RST;
			hub_flag_q <= 1'b0;
			addr_flag_q <= 1'b0;
			name_q <= smdc_pkg::NAME_DEFAULT;
			nv_loaded_q <= 1'b0;
			name_rej_q <= 1'b0;
		end else begin
			if (!nv_loaded_q && i_nv_valid) begin
				nv_loaded_q <= 1'b1;
				name_q <= i_nv_name;
				addr_flag_q <= i_nv_addr_flag;
			end else begin
				if (wr_mode) begin
					hub_flag_q <= i_wdata[smdc_pkg::MODE_HUB_BIT];
					addr_flag_q <= i_wdata[smdc_pkg::MODE_ADDR_BIT];
				end
				if (wr_name && name_ok) begin
					name_q <= i_wdata;
				end
			end
			if (wr_baud) begin
				baud_q <= i_wdata[1:0];
			end
			if (wr_name) begin
				name_rej_q <= !name_ok;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			txd_q <= 8'h00;
			tx_req_q <= 1'b0;
			rxd_q <= 8'h00;
			rx_new_q <= 1'b0;
			msg_sel_q <= 1'b0;
			msg_start_q <= 1'b1;
		end else begin
			if (wr_txd) begin
				txd_q <= i_wdata;
			end
			tx_req_q <= wr_txd | (tx_req_q & ~local_go);
			if (accept) begin
				rxd_q <= host_rx_d;
			end
			rx_new_q <= accept | (rx_new_q & ~rd_rxd);
			if (host_rx_v) begin
				msg_start_q <= msg_end;
				msg_sel_q <= msg_end ? 1'b0 : sel_now;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_rdata <= 8'h00;
			o_rs232_tx <= 1'b1;
			o_rs485_tx <= 1'b1;
			o_rs485_oe <= 1'b0;
			o_nv_we <= 1'b0;
			o_nv_name <= 8'h00;
			o_nv_addr_flag <= 1'b0;
			o_hub_active <= 1'b0;
			o_addressed_active <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rd_mux : 8'h00;
			o_rs232_tx <= t232_tx;
			o_rs485_tx <= t485_tx;
			o_rs485_oe <= t485_busy;
			o_nv_we <= wr_cmd && i_wdata[smdc_pkg::CMD_SAVE_BIT];
			if (wr_cmd && i_wdata[smdc_pkg::CMD_SAVE_BIT]) begin
				o_nv_name <= name_q;
				o_nv_addr_flag <= addr_flag_q;
			end
			o_hub_active <= hub_on;
			o_addressed_active <= addr_on;
		end
	end
endmodule

// [smdc_uart_rx.sv]
// Serial receiver, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
module smdc_uart_rx #(
	parameter int DW = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_div,
	input wire logic i_rx,
	output logic o_valid,
	output logic [DW-1:0] o_data
);
	typedef enum logic [1:0] {SMDC_RX_IDLE, SMDC_RX_START, SMDC_RX_DATA, SMDC_RX_STOP} smdc_rx_st_t;
	smdc_rx_st_t st_q;
	logic [15:0] cnt_q;
	logic [3:0] bit_q;
	logic [DW-1:0] sh_q;
	logic rx_s1_q, rx_s2_q;
	wire tick = (cnt_q == 16'h0000);
	wire [15:0] half = {1'b0, i_div[15:1]};
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= SMDC_RX_IDLE;
			cnt_q <= 16'h0000;
			bit_q <= 4'h0;
			sh_q <= '0;
			o_valid <= 1'b0;
			o_data <= '0;
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= i_rx;
			rx_s2_q <= rx_s1_q;
			o_valid <= 1'b0;
			cnt_q <= tick ? i_div - 16'h0001 : cnt_q - 16'h0001;
			case (st_q)
				SMDC_RX_IDLE: begin
					if (!rx_s2_q) begin
						st_q <= SMDC_RX_START;
						cnt_q <= half;
					end
				end
				SMDC_RX_START: begin
					if (tick) begin
						st_q <= rx_s2_q ? SMDC_RX_IDLE : SMDC_RX_DATA;
						bit_q <= 4'h0;
					end
				end
				SMDC_RX_DATA: begin
					if (tick) begin
						sh_q <= {rx_s2_q, sh_q[DW-1:1]};
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'(DW - 1)) begin
							st_q <= SMDC_RX_STOP;
						end
					end
				end
				SMDC_RX_STOP: begin
					if (tick) begin
						st_q <= SMDC_RX_IDLE;
						o_valid <= rx_s2_q;
						o_data <= sh_q;
					end
				end
				default: st_q <= SMDC_RX_IDLE;
			endcase
		end
	end
endmodule

// [smdc_uart_tx.sv]
// Serial transmitter, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
module smdc_uart_tx #(
	parameter int DW = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_div,
	input wire logic i_start,
	input wire logic [DW-1:0] i_data,
	output logic o_busy,
	output logic o_tx
);
	logic [15:0] cnt_q;
	logic [3:0] bit_q;
	logic [DW+1:0] sh_q;
	wire tick = (cnt_q == 16'h0000);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 16'h0000;
			bit_q <= 4'h0;
			sh_q <= '1;
			o_busy <= 1'b0;
			o_tx <= 1'b1;
		end else if (!o_busy) begin
			o_tx <= 1'b1;
			if (i_start) begin
				sh_q <= {1'b1, i_data, 1'b0};
				bit_q <= 4'(DW + 2);
				cnt_q <= 16'h0000;
				o_busy <= 1'b1;
			end
		end else begin
			cnt_q <= tick ? i_div - 16'h0001 : cnt_q - 16'h0001;
			if (tick) begin
				if (bit_q == 4'h0) begin
					o_busy <= 1'b0;
					o_tx <= 1'b1;
				end else begin
					o_tx <= sh_q[0];
					sh_q <= {1'b1, sh_q[DW+1:1]};
					bit_q <= bit_q - 4'h1;
				end
			end
		end
	end
endmodule

// [tb_top.sv]
// Testbench for the serial multidrop front end
`timescale 1ns/1ps
module tb_top;
	logic i_core_clk, i_arst_n, i_hub_role_switch, i_addressed_mode_switch, i_wr, i_rd, rx232, rx485;
	logic o_rs232_tx, o_rs485_tx, o_rs485_oe, o_nv_we, o_hub_active, o_addressed_active, o_nv_addr_flag;
	logic nv_flag, nv_valid;
	logic [7:0] nv_name;
	logic [2:0] i_node_address_switches;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata, o_nv_name, r;
	logic [15:0] dv;
	int n_fail, num_checks, seed, mbaud, mname, k;
	smdc_top smdc_top_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_hub_role_switch(i_hub_role_switch),
		.i_addressed_mode_switch(i_addressed_mode_switch), .i_node_address_switches(i_node_address_switches),
		.i_nv_name(nv_name), .i_nv_addr_flag(nv_flag), .i_nv_valid(nv_valid), .i_rs232_rx(rx232), .i_rs485_rx(rx485),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rs232_tx(o_rs232_tx),
		.o_rs485_tx(o_rs485_tx), .o_rs485_oe(o_rs485_oe), .o_nv_we(o_nv_we), .o_nv_name(o_nv_name),
		.o_nv_addr_flag(o_nv_addr_flag), .o_hub_active(o_hub_active), .o_addressed_active(o_addressed_active));
	smdc_peer p232_i (.i_clk(i_core_clk), .i_div(dv), .i_line(o_rs232_tx), .o_line(rx232));
	smdc_peer p485_i (.i_clk(i_core_clk), .i_div(dv), .i_line(o_rs485_tx), .o_line(rx485));
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata & m, e);
	endtask
	task automatic pop(input bit w, input logic [7:0] e);
		for (int j = 0; j < 6000; j++) begin
			if (w ? p485_i.q.size() > 0 : p232_i.q.size() > 0) break;
			@(posedge i_core_clk);
		end
		chk(w ? p485_i.q.pop_front() : p232_i.q.pop_front(), e);
	endtask
	task automatic sw(input logic h, input logic [2:0] v);
		@(posedge i_core_clk);
		i_hub_role_switch <= h;
		i_node_address_switches <= v;
		repeat (4) @(posedge i_core_clk);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge i_core_clk);
		n_fail++;
		conclude;
	end
	initial begin
		{i_arst_n, i_hub_role_switch, i_addressed_mode_switch, i_wr, i_rd} = 5'h00;
		{i_node_address_switches, i_addr, i_wdata} = 15'h0000;
		{nv_name, nv_flag, nv_valid} = 10'h000;
		seed = 19834;
		mbaud = 19200;
		mname = 8'h21;
		dv = 16'(10000000 / mbaud);
		repeat (3) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		rdc(smdc_pkg::ADDR_BAUD, 8'h02);
		rdc(smdc_pkg::ADDR_MODE, 8'h00);
		rdc(smdc_pkg::ADDR_NAME, 8'(mname));
		rdc(4'hf, 8'h00);
		chk({6'h00, o_hub_active, o_addressed_active}, 8'h00);
		r = 8'($random(seed));
		wr(smdc_pkg::ADDR_TXD, r);
		pop(1, r);
		r = 8'($random(seed));
		p485_i.send(r);
		rdc(smdc_pkg::ADDR_RXD, r);
		for (int s = 0; s < 4; s++) begin
			wr(smdc_pkg::ADDR_BAUD, 8'(s));
			rdc(smdc_pkg::ADDR_BAUD, 8'(s));
		end
		mbaud = 38400;
		dv = 16'(10000000 / mbaud);
		mname = 8'h35;
		wr(smdc_pkg::ADDR_NAME, 8'h7a);
		rdc(smdc_pkg::ADDR_NAME, 8'h7a);
		wr(smdc_pkg::ADDR_NAME, 8'(mname));
		wr(smdc_pkg::ADDR_NAME, 8'h23);
		rdc(smdc_pkg::ADDR_NAME, 8'(mname));
		for (int v = 1; v < 8; v++) begin
			sw(1'b0, 3'(v));
			rdc(smdc_pkg::ADDR_NAME, 8'h40 + 8'(v));
		end
		sw(1'b0, 3'h0);
		rdc(smdc_pkg::ADDR_NAME, 8'(mname));
		wr(smdc_pkg::ADDR_CMD, 8'h01);
		#1 k = 0;
		while (k < 5 && o_nv_we !== 1'b1) begin
			@(posedge i_core_clk);
			#1 k++;
		end
		chk(8'(k < 5), 8'h01);
		chk(o_nv_name, 8'(mname));
		sw(1'b1, 3'h0);
		chk(8'(o_hub_active), 8'h01);
		r = 8'($random(seed));
		p232_i.send(r);
		pop(1, r);
		r = 8'($random(seed));
		p485_i.send(r);
		pop(0, r);
		wr(smdc_pkg::ADDR_MODE, 8'h01);
		sw(1'b0, 3'h0);
		chk(8'(o_hub_active), 8'h01);
		wr(smdc_pkg::ADDR_MODE, 8'h02);
		repeat (4) @(posedge i_core_clk);
		chk({o_hub_active, o_addressed_active}, 8'h01);
		rdc(smdc_pkg::ADDR_STATUS, 8'h00, 8'h20);
		p485_i.send(8'h0d);
		p485_i.send(8'(mname));
		p485_i.send(8'h51);
		rdc(smdc_pkg::ADDR_RXD, 8'h51);
		p485_i.send(8'h0d);
		rdc(smdc_pkg::ADDR_RXD, 8'h0d);
		p485_i.send(8'h78);
		p485_i.send(8'h52);
		rdc(smdc_pkg::ADDR_STATUS, 8'h00, 8'h02);
		wr(smdc_pkg::ADDR_CMD, 8'h01);
		#1 chk(8'(o_nv_addr_flag), 8'h01);
		wr(smdc_pkg::ADDR_MODE, 8'h00);
		@(posedge i_core_clk);
		i_addressed_mode_switch <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		chk(8'(o_addressed_active), 8'h01);
		rdc(smdc_pkg::ADDR_STATUS, 8'h00, 8'h20);
		@(posedge i_core_clk);
		i_addressed_mode_switch <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		chk(8'(o_addressed_active), 8'h00);
		rdc(smdc_pkg::ADDR_STATUS, 8'h20, 8'h20);
		@(posedge i_core_clk);
		i_arst_n <= 1'b0;
		nv_name <= 8'(mname);
		nv_flag <= 1'b1;
		nv_valid <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		chk(8'(o_addressed_active), 8'h01);
		rdc(smdc_pkg::ADDR_MODE, 8'h02);
		rdc(smdc_pkg::ADDR_NAME, 8'(mname));
		rdc(smdc_pkg::ADDR_STATUS, 8'h01, 8'h01);
		conclude;
	end
endmodule
